// ### exec_unit.sv
// Execution unit for shifts, flag ops, memory transfers and control ops
//
// Decided for this implementation: strobed register access and the register offsets.
module exec_unit (
   input wire logic ref_clk_in, // 100 MHz clock
   input wire logic rst_in, // Synchronous reset, active high
   input wire logic valid_in, // Instruction present
   input wire logic [4:0] op_in, // Operation code
   input wire logic [4:0] rd_in, // Destination register index
   input wire logic [4:0] rr_in, // Source register index
   input wire logic [2:0] bit_in, // Bit or flag select
   input wire logic [1:0] mode_in, // Plain, post-inc or pre-dec
   input wire logic [1:0] ptr_sel_in, // Pointer select X, Y or Z
   input wire logic [5:0] disp_in, // Unsigned displacement
   input wire logic [15:0] addr_in, // Absolute data address
   output logic ready_out, // Unit can take an instruction
   output logic [15:0] dmem_addr_out, // Data memory address
   output logic [7:0] dmem_wdata_out, // Data memory write data
   output logic dmem_we_out, // Data memory write strobe
   output logic dmem_re_out, // Data memory read strobe
   input wire logic [7:0] dmem_rdata_in, // Read data while read strobe high
   output logic [15:0] pmem_addr_out, // Program memory byte address
   output logic pmem_re_out, // Program memory read strobe
   input wire logic [7:0] pmem_rdata_in, // Byte, cycle after read strobe
   output logic [7:0] flags_out, // Status flags register
   output logic [15:0] sp_out, // Stack pointer
   output logic sleep_out, // Sleep request pulse
   output logic wdt_restart_out, // Watchdog restart pulse
   output logic break_out, // Debug break pulse
   input wire logic [4:0] dbg_idx_in, // Register file peek index
   output logic [7:0] dbg_data_out // Peeked register, one cycle later
);

   ////////////////////////////////////////////////////////////////////////
   // Storage and state
   logic [7:0] regs_r [exec_pkg::REG_COUNT];
   logic [7:0] flags_r;
   logic [7:0] flags_nxt;
   logic [15:0] sp_r;
   logic [15:0] sp_nxt;
   exec_pkg::state_type state_r;
   exec_pkg::state_type state_nxt;
   logic [4:0] pend_rd_r;
   logic [15:0] dmem_addr_r;
   logic [7:0] dmem_wdata_r;
   logic dmem_we_r;
   logic dmem_re_r;
   logic [15:0] pmem_addr_r;
   logic pmem_re_r;
   logic sleep_r;
   logic wdt_r;
   logic break_r;
   logic [7:0] dbg_r;

   ////////////////////////////////////////////////////////////////////////
   // Operand decode
   wire take = valid_in & (state_r == exec_pkg::ST_IDLE);
   wire is_rlc = take & (op_in == exec_pkg::OP_RLC);
   wire is_rrc = take & (op_in == exec_pkg::OP_RRC);
   wire is_sra = take & (op_in == exec_pkg::OP_SRA);
   wire is_swap = take & (op_in == exec_pkg::OP_SWAP);
   wire is_fset = take & (op_in == exec_pkg::OP_FSET);
   wire is_fclr = take & (op_in == exec_pkg::OP_FCLR);
   wire is_b2t = take & (op_in == exec_pkg::OP_B2T);
   wire is_t2b = take & (op_in == exec_pkg::OP_T2B);
   wire is_pair = take & (op_in == exec_pkg::OP_PAIR);
   wire is_ld = take & (op_in == exec_pkg::OP_LD);
   wire is_ldo = take & (op_in == exec_pkg::OP_LDO);
   wire is_lda = take & (op_in == exec_pkg::OP_LDA);
   wire is_st = take & (op_in == exec_pkg::OP_ST);
   wire is_sto = take & (op_in == exec_pkg::OP_STO);
   wire is_sta = take & (op_in == exec_pkg::OP_STA);
   wire is_pmr = take & (op_in == exec_pkg::OP_PMR);
   wire is_push = take & (op_in == exec_pkg::OP_PUSH);
   wire is_pop = take & (op_in == exec_pkg::OP_POP);
   wire is_sleep = take & (op_in == exec_pkg::OP_SLEEP);
   wire is_wdt = take & (op_in == exec_pkg::OP_WDT);
   wire is_break = take & (op_in == exec_pkg::OP_BREAK);
   wire is_shift = is_rlc | is_rrc | is_sra;
   wire is_load = is_ld | is_ldo | is_lda | is_pop;
   wire is_store = is_st | is_sto | is_sta | is_push;

   wire [7:0] rd_val = regs_r[rd_in];
   wire [7:0] rr_val = regs_r[rr_in];
   wire carry = flags_r[exec_pkg::FLAG_C];
   wire tflag = flags_r[exec_pkg::FLAG_T];
   wire [7:0] bit_mask = 8'h01 << bit_in;

   ////////////////////////////////////////////////////////////////////////
   // Pointer selection and address arithmetic
   wire [4:0] ptr_lo_idx = (ptr_sel_in == exec_pkg::PTR_Y) ?
      exec_pkg::Y_LO_IDX : (ptr_sel_in == exec_pkg::PTR_Z) ?
      exec_pkg::Z_LO_IDX : exec_pkg::X_LO_IDX;
   wire [4:0] pmr_lo_idx = exec_pkg::Z_LO_IDX;
   wire [4:0] ptr_idx = is_pmr ? pmr_lo_idx : ptr_lo_idx;
   wire [15:0] ptr_val = {regs_r[ptr_idx | 5'h01], regs_r[ptr_idx]};
   wire [15:0] ptr_inc = ptr_val + exec_pkg::ONE_16;
   wire [15:0] ptr_dec = ptr_val - exec_pkg::ONE_16;
   wire [15:0] ptr_disp = ptr_val + {10'h000, disp_in};
   wire post_inc = mode_in == exec_pkg::MODE_POST_INC;
   wire pre_dec = mode_in == exec_pkg::MODE_PRE_DEC;
   wire [15:0] sp_inc = sp_r + exec_pkg::ONE_16;
   wire [15:0] sp_dec = sp_r - exec_pkg::ONE_16;

   // Address presented to data memory for this instruction
   wire [15:0] ind_addr = pre_dec ? ptr_dec : ptr_val; // [RL7] [RL10]
   wire [15:0] mem_addr = (is_ld | is_st) ? ind_addr :
      (is_ldo | is_sto) ? ptr_disp : // [RL8] [RL11]
      (is_lda | is_sta) ? addr_in : // [RL12] [RL13]
      is_pop ? sp_inc : sp_r; // [RL15] [RL16]
   wire [7:0] store_data = rr_val;

   // Pointer register update: post-increment or pre-decrement only
   wire ptr_step = ((is_ld | is_st) & (post_inc | pre_dec)) |
      (is_pmr & post_inc);
   wire [15:0] ptr_new = pre_dec & ~is_pmr ? ptr_dec : ptr_inc;

   ////////////////////////////////////////////////////////////////////////
   // Shift, rotate, swap and bit-load results
   wire [7:0] rlc_res = {rd_val[6:0], carry}; // [RL1]
   wire [7:0] rrc_res = {carry, rd_val[7:1]}; // [RL2]
   wire [7:0] sra_res = {rd_val[7], rd_val[7:1]}; // [RL20]
   wire [7:0] swap_res = {rd_val[3:0], rd_val[7:4]}; // [RL21]
   wire [7:0] t2b_res = tflag ? (rd_val | bit_mask) :
      (rd_val & ~bit_mask); // [RL4]
   wire [7:0] shift_res = is_rlc ? rlc_res : is_rrc ? rrc_res : sra_res;
   wire shift_c = is_rlc ? rd_val[7] : rd_val[0]; // [RL1] [RL2] [RL20]
   wire shift_n = shift_res[7];
   wire shift_z = shift_res == 8'h00;
   wire shift_v = shift_n ^ shift_c;

   ////////////////////////////////////////////////////////////////////////
   // Register file byte write port and pair write port
   wire pm_done = state_r == exec_pkg::ST_PM_DATA;
   wire mem_done = (state_r == exec_pkg::ST_MEM) & dmem_re_r;
   wire byte_we = is_shift | is_swap | is_t2b | mem_done | pm_done;
   wire [4:0] byte_idx = (mem_done | pm_done) ? pend_rd_r : rd_in;
   wire [7:0] byte_data = mem_done ? dmem_rdata_in : // [RL6] [RL12]
      pm_done ? pmem_rdata_in : // [RL14]
      is_shift ? shift_res : is_swap ? swap_res : t2b_res;
   wire pair_we = is_pair | ptr_step;
   wire [4:0] pair_idx = is_pair ? {rd_in[4:1], 1'b0} : ptr_idx;
   wire [15:0] pair_data = is_pair ?
      {regs_r[{rr_in[4:1], 1'b1}], regs_r[{rr_in[4:1], 1'b0}]} :
      ptr_new; // [RL22] [RL6] [RL9]

   // One process per register entry
   generate
      for (genvar i = 0; i < exec_pkg::REG_COUNT; i++) begin : g_regs
         localparam logic [4:0] IDX = 5'(i);
         always_ff @(posedge ref_clk_in) begin
            if (rst_in) begin
               regs_r[i] <= exec_pkg::REG_RESET;
            end else if (byte_we && byte_idx == IDX) begin
               regs_r[i] <= byte_data;
            end else if (pair_we && pair_idx[4:1] == IDX[4:1]) begin
               regs_r[i] <= IDX[0] ? pair_data[15:8] : pair_data[7:0];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Status flags next value
   always_comb begin
      flags_nxt = flags_r;
      if (is_shift) begin
         flags_nxt[exec_pkg::FLAG_C] = shift_c; // [RL1] [RL2] [RL20]
         flags_nxt[exec_pkg::FLAG_Z] = shift_z;
         flags_nxt[exec_pkg::FLAG_N] = shift_n;
         flags_nxt[exec_pkg::FLAG_V] = shift_v;
      end else if (is_fset) begin
         flags_nxt = flags_r | bit_mask; // [RL5]
      end else if (is_fclr) begin
         flags_nxt = flags_r & ~bit_mask; // [RL5]
      end else if (is_b2t) begin
         flags_nxt[exec_pkg::FLAG_T] = |(rd_val & bit_mask); // [RL3]
      end
   end

   // Stack pointer: push after-decrements, pop pre-increments
   assign sp_nxt = is_push ? sp_dec : is_pop ? sp_inc : sp_r; // [RL15] [RL16]

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: memory ops hold one extra cycle, program reads two
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         exec_pkg::ST_IDLE: begin
            if (is_load | is_store) begin
               state_nxt = exec_pkg::ST_MEM; // [RL6] [RL9] [RL15]
            end else if (is_pmr) begin
               state_nxt = exec_pkg::ST_PM_ADDR; // [RL14]
            end
         end
         exec_pkg::ST_MEM: begin
            state_nxt = exec_pkg::ST_IDLE;
         end
         exec_pkg::ST_PM_ADDR: begin
            state_nxt = exec_pkg::ST_PM_DATA;
         end
         exec_pkg::ST_PM_DATA: begin
            state_nxt = exec_pkg::ST_IDLE;
         end
         default: begin
            state_nxt = exec_pkg::ST_IDLE;
         end
      endcase
   end

   // State, flags, stack pointer and pending destination
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state_r <= exec_pkg::ST_IDLE;
         flags_r <= exec_pkg::FLAGS_RESET;
         sp_r <= exec_pkg::SP_RESET;
         pend_rd_r <= 5'h00;
      end else begin
         state_r <= state_nxt;
         flags_r <= flags_nxt;
         sp_r <= sp_nxt;
         if (take) begin
            pend_rd_r <= rd_in;
         end
      end
   end

   // Data memory strobes, held for the second cycle only
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         dmem_addr_r <= 16'h0000;
         dmem_wdata_r <= 8'h00;
         dmem_we_r <= 1'b0;
         dmem_re_r <= 1'b0;
      end else begin
         dmem_we_r <= is_store; // [RL9] [RL10] [RL11] [RL13] [RL15]
         dmem_re_r <= is_load; // [RL6] [RL7] [RL8] [RL12] [RL16]
         if (is_load | is_store) begin
            dmem_addr_r <= mem_addr;
            dmem_wdata_r <= store_data;
         end
      end
   end

   // Program memory address from Z, strobe in the second cycle
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         pmem_addr_r <= 16'h0000;
         pmem_re_r <= 1'b0;
      end else begin
         pmem_re_r <= is_pmr; // [RL14]
         if (is_pmr) begin
            pmem_addr_r <= ptr_val;
         end
      end
   end

   // Control pulses to sleep, watchdog and debug logic
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sleep_r <= 1'b0;
         wdt_r <= 1'b0;
         break_r <= 1'b0;
      end else begin
         sleep_r <= is_sleep; // [RL17]
         wdt_r <= is_wdt; // [RL18]
         break_r <= is_break; // [RL19]
      end
   end

   // Register peek for software visibility
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         dbg_r <= 8'h00;
      end else begin
         dbg_r <= regs_r[dbg_idx_in];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign ready_out = state_r == exec_pkg::ST_IDLE;
   assign dmem_addr_out = dmem_addr_r;
   assign dmem_wdata_out = dmem_wdata_r;
   assign dmem_we_out = dmem_we_r;
   assign dmem_re_out = dmem_re_r;
   assign pmem_addr_out = pmem_addr_r;
   assign pmem_re_out = pmem_re_r;
   assign flags_out = flags_r;
   assign sp_out = sp_r;
   assign sleep_out = sleep_r;
   assign wdt_restart_out = wdt_r;
   assign break_out = break_r;
   assign dbg_data_out = dbg_r;

endmodule // exec_unit

// ### exec_pkg.sv
// Constants and types for the instruction execution subset
// Behaviour
// RL1: rotate_left_carry: carry into bit 0, bit 7 into carry; Z,C,N,V; 1 cycle
// RL2: rotate_right_carry: carry into bit 7, bit 0 into carry; Z,C,N,V; 1 cycle
// RL3: bit_to_transfer_flag copies selected source bit into T only, 1 cycle
// RL4: transfer_flag_to_bit writes T into selected destination bit, 1 cycle
// RL5: Each flag force high or low changes only that flag, 1 cycle
// RL6: Post-increment load reads at pointer, then pointer plus one; 2 cycles
// RL7: Pre-decrement load subtracts one first, reads new address; 2 cycles
// RL8: load_with_offset reads at Y or Z plus displacement; pointer kept; 2 cycles
// RL9: Post-increment store writes at pointer, then pointer plus one; 2 cycles
// RL10: Pre-decrement store subtracts one first, writes new address; 2 cycles
// RL11: store_with_offset writes at Y or Z plus displacement; 2 cycles
// RL12: load_direct reads absolute address into destination, 2 cycles
// RL13: store_direct writes source to absolute address, 2 cycles
// RL14: program_memory_read fetches byte at Z, optional post-increment; 3 cycles
// RL15: Push stores source at stack pointer and adjusts it; 2 cycles
// RL16: Pop adjusts stack pointer and loads destination; 2 cycles
// RL17: Sleep issues in 1 cycle and signals the sleep logic
// RL18: watchdog_restart signals the watchdog in 1 cycle, no flags
// RL19: Break only signals the debug facility, no flag changes
// RL20: arith_shift_right keeps bit 7, old bit 0 to carry; Z,C,N,V; 1 cycle
// RL21: Nibble swap exchanges register halves in 1 cycle, no flags
// RL22: copy_register_pair copies an even pair to an even pair, 1 cycle
package exec_pkg;
   localparam int REG_COUNT = 32;
   localparam logic [4:0] X_LO_IDX = 5'h1a;
   localparam logic [4:0] Y_LO_IDX = 5'h1c;
   localparam logic [4:0] Z_LO_IDX = 5'h1e;
   localparam logic [1:0] PTR_X = 2'h0;
   localparam logic [1:0] PTR_Y = 2'h1;
   localparam logic [1:0] PTR_Z = 2'h2;
   localparam logic [1:0] MODE_PLAIN = 2'h0;
   localparam logic [1:0] MODE_POST_INC = 2'h1;
   localparam logic [1:0] MODE_PRE_DEC = 2'h2;
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_T = 6;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [15:0] SP_RESET = 16'h0000;
   localparam logic [15:0] ONE_16 = 16'h0001;
   localparam logic [7:0] REG_RESET = 8'h00;
   // Operation codes presented by the fetch path
   typedef enum logic [4:0] {
      OP_NOP = 5'h00,
      OP_RLC = 5'h01,
      OP_RRC = 5'h02,
      OP_SRA = 5'h03,
      OP_SWAP = 5'h04,
      OP_FSET = 5'h05,
      OP_FCLR = 5'h06,
      OP_B2T = 5'h07,
      OP_T2B = 5'h08,
      OP_PAIR = 5'h09,
      OP_LD = 5'h0a,
      OP_LDO = 5'h0b,
      OP_LDA = 5'h0c,
      OP_ST = 5'h0d,
      OP_STO = 5'h0e,
      OP_STA = 5'h0f,
      OP_PMR = 5'h10,
      OP_PUSH = 5'h11,
      OP_POP = 5'h12,
      OP_SLEEP = 5'h13,
      OP_WDT = 5'h14,
      OP_BREAK = 5'h15
   } op_type;
   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_MEM = 4'b0010,
      ST_PM_ADDR = 4'b0100,
      ST_PM_DATA = 4'b1000
   } state_type;
endpackage

// ### exec_unit_assertions.sv
// Port-level assertions for the execution unit
module exec_unit_assertions (
   input wire logic ref_clk_in, // Clock
   input wire logic rst_in, // Reset
   input wire logic valid_in, // Instruction present
   input wire logic [4:0] op_in, // Operation code
   input wire logic [2:0] bit_in, // Flag select
   input wire logic [15:0] addr_in, // Absolute address
   input wire logic ready_out, // Idle
   input wire logic [15:0] dmem_addr_out, // Data address
   input wire logic dmem_we_out, // Write strobe
   input wire logic dmem_re_out, // Read strobe
   input wire logic [7:0] flags_out, // Flags
   input wire logic [15:0] sp_out, // Stack pointer
   input wire logic sleep_out, // Sleep pulse
   input wire logic wdt_restart_out // Watchdog pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   logic mem_op;
   // Two-cycle data memory operations
   assign mem_op = op_in inside {exec_pkg::OP_LD, exec_pkg::OP_LDO,
      exec_pkg::OP_LDA, exec_pkg::OP_ST, exec_pkg::OP_STO, exec_pkg::OP_STA,
      exec_pkg::OP_PUSH, exec_pkg::OP_POP};
   //////////////////////////////////////////////////////////////////////////
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   // Instruction of the given code accepted
   sequence tk(logic [4:0] code);
      valid_in && ready_out && op_in == code;
   endsequence
   // Busy for one cycle, then idle again
   sequence one_busy;
      !ready_out ##1 ready_out;
   endsequence
   a_sleep_pulse: assert property (
      tk(exec_pkg::OP_SLEEP) |=> sleep_out ##1 !sleep_out)
      else $error("sleep pulse wrong");
   a_wdt_pulse: assert property (
      tk(exec_pkg::OP_WDT) |=> wdt_restart_out && $stable(flags_out))
      else $error("watchdog pulse wrong");
   a_mem_two: assert property (
      valid_in && ready_out && mem_op |=> one_busy)
      else $error("memory op not two cycles");
   a_mem_flags: assert property (
      valid_in && ready_out && mem_op |=> $stable(flags_out) [*2])
      else $error("memory op changed flags");
   a_pmr_three: assert property (
      tk(exec_pkg::OP_PMR) |=> !ready_out ##1 one_busy)
      else $error("program read not three cycles");
   a_lda_addr: assert property (
      tk(exec_pkg::OP_LDA) |=> dmem_re_out && dmem_addr_out == $past(addr_in))
      else $error("direct load address wrong");
   a_push_stack: assert property (
      tk(exec_pkg::OP_PUSH) |=> dmem_we_out && dmem_addr_out == $past(sp_out)
      && sp_out == $past(sp_out) - 16'h0001)
      else $error("push stack wrong");
   a_pop_stack: assert property (
      tk(exec_pkg::OP_POP) |=> dmem_re_out && dmem_addr_out == sp_out
      && sp_out == $past(sp_out) + 16'h0001)
      else $error("pop stack wrong");
   a_flag_set: assert property (
      tk(exec_pkg::OP_FSET) |=>
      flags_out == ($past(flags_out) | 8'h01 << $past(bit_in)))
      else $error("flag set wrong");
   a_b2t_only: assert property (
      tk(exec_pkg::OP_B2T) |=> ((flags_out ^ $past(flags_out)) & 8'hbf) == 0)
      else $error("bit store touched other flags");
endmodule // exec_unit_assertions

bind exec_unit exec_unit_assertions chk_u (.ref_clk_in, .rst_in, .valid_in,
   .op_in, .bit_in, .addr_in, .ready_out, .dmem_addr_out, .dmem_we_out,
   .dmem_re_out, .flags_out, .sp_out, .sleep_out, .wdt_restart_out);

// ### exec_mem_model.sv
// Data and program memory partner for the execution unit
module exec_mem_model (
   input wire logic ref_clk_in, // Clock
   input wire logic [15:0] daddr_in, // Data address
   input wire logic [7:0] wdata_in, // Write data
   input wire logic we_in, // Write strobe
   input wire logic re_in, // Read strobe
   output logic [7:0] rdata_out, // Read data
   input wire logic [15:0] paddr_in, // Program byte address
   input wire logic pre_in, // Program read strobe
   output logic [7:0] prdata_out // Program byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem_r [256];
   logic [7:0] pbyte_r = 8'h00;
   logic pvalid_r = 1'b0;
   initial foreach (mem_r[i]) mem_r[i] = 8'(i) ^ 8'h5a;
   // Outside a strobe show the inverse, so stale use is caught
   assign rdata_out = re_in ? mem_r[daddr_in[7:0]] : ~mem_r[daddr_in[7:0]];
   assign prdata_out = pvalid_r ? pbyte_r : ~pbyte_r;
   // Writes land on the edge; the program byte follows its strobe
   always @(posedge ref_clk_in) begin
      if (we_in) mem_r[daddr_in[7:0]] <= wdata_in;
      pvalid_r <= pre_in;
      pbyte_r <= paddr_in[7:0] ^ 8'ha5;
   end
endmodule // exec_mem_model

// ### cpu_instruction_execution_subset_bench.sv
// Self-checking bench for the instruction execution subset
module cpu_instruction_execution_subset_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_in = 1'b0;
   logic rst_in, valid_in, ready_out, dmem_we_out, dmem_re_out, pmem_re_out;
   logic sleep_out, wdt_restart_out, break_out;
   logic [4:0] op_in, rd_in, rr_in, dbg_idx_in, r;
   logic [2:0] bit_in;
   logic [1:0] mode_in, ptr_sel_in;
   logic [5:0] disp_in;
   logic [15:0] addr_in, dmem_addr_out, pmem_addr_out, sp_out, sp, ea;
   logic [7:0] dmem_wdata_out, dmem_rdata_in, pmem_rdata_in, flags_out;
   logic [7:0] dbg_data_out, fl;
   logic [7:0] rf [32];
   logic [7:0] mem [256];
   int fail_count = 0;
   int tests_run = 0;

   exec_unit dut_u (.ref_clk_in, .rst_in, .valid_in, .op_in, .rd_in, .rr_in,
      .bit_in, .mode_in, .ptr_sel_in, .disp_in, .addr_in, .ready_out,
      .dmem_addr_out, .dmem_wdata_out, .dmem_we_out, .dmem_re_out,
      .dmem_rdata_in, .pmem_addr_out, .pmem_re_out, .pmem_rdata_in,
      .flags_out, .sp_out, .sleep_out, .wdt_restart_out, .break_out,
      .dbg_idx_in, .dbg_data_out);
   exec_mem_model mem_u (.ref_clk_in, .daddr_in(dmem_addr_out),
      .wdata_in(dmem_wdata_out), .we_in(dmem_we_out), .re_in(dmem_re_out),
      .rdata_out(dmem_rdata_in), .paddr_in(pmem_addr_out),
      .pre_in(pmem_re_out), .prdata_out(pmem_rdata_in));

   always #5 ref_clk_in = ~ref_clk_in;

   task automatic check(input logic [15:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   function automatic logic [4:0] pick();
      return 5'(16 + $urandom % 10);
   endfunction

   // Every memory strobe carries the address the model predicts
   always @(posedge ref_clk_in) begin
      if (dmem_we_out === 1'b1 || dmem_re_out === 1'b1) begin
         check(dmem_addr_out, ea); // Address
      end
      if (dmem_we_out === 1'b1) begin
         check(16'(dmem_wdata_out), 16'(mem[ea[7:0]])); // Data
      end
      if (pmem_re_out === 1'b1) begin
         check(pmem_addr_out, ea); // Program address
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Advance the model, issue one instruction, check timing and flags
   task automatic run(input logic [4:0] op, rd, rr, input logic [2:0] b,
         input logic [1:0] m, p, input logic [5:0] q, input logic [15:0] a);
      logic [7:0] d, res;
      logic [15:0] pt;
      int n, cyc;
      d = rf[rd];
      case (op)
         exec_pkg::OP_RLC: res = {d[6:0], fl[0]}; // Rotate left
         exec_pkg::OP_RRC: res = {fl[0], d[7:1]}; // Rotate right
         exec_pkg::OP_SRA: res = {d[7], d[7:1]}; // Sign kept
         exec_pkg::OP_SWAP: res = {d[3:0], d[7:4]}; // Halves
         exec_pkg::OP_T2B: res = d & ~(8'h01 << b) | {7'h00, fl[6]} << b;
         default: res = d;
      endcase
      if (op inside {exec_pkg::OP_RLC, exec_pkg::OP_RRC, exec_pkg::OP_SRA})
            begin
         fl[0] = op == exec_pkg::OP_RLC ? d[7] : d[0]; // Carry out
         fl[3:1] = {res[7] ^ fl[0], res[7], res == 8'h00}; // V N Z
      end
      if (op == exec_pkg::OP_FSET) fl[b] = 1'b1; // Own flag
      if (op == exec_pkg::OP_FCLR) fl[b] = 1'b0; // Own flag
      if (op == exec_pkg::OP_B2T) fl[6] = d[b]; // Transfer flag
      rf[rd] = res; // Bit load
      if (op == exec_pkg::OP_PAIR) begin
         rf[{rd[4:1], 1'b0}] = rf[{rr[4:1], 1'b0}]; // Low byte
         rf[{rd[4:1], 1'b1}] = rf[{rr[4:1], 1'b1}]; // High byte
      end
      pt = {rf[27 + 2 * p], rf[26 + 2 * p]};
      ea = pt;
      cyc = op >= exec_pkg::OP_LD && op <= exec_pkg::OP_POP ? 2 : 1;
      case (op)
         exec_pkg::OP_LD, exec_pkg::OP_ST: begin
            ea = pt - 16'(m == exec_pkg::MODE_PRE_DEC); // First
            pt = ea + 16'(m == exec_pkg::MODE_POST_INC); // After
         end
         exec_pkg::OP_LDO, exec_pkg::OP_STO: ea = pt + 16'(q);
         exec_pkg::OP_LDA, exec_pkg::OP_STA: ea = a; // Absolute
         exec_pkg::OP_PUSH: sp = sp - 16'h0001; // Post-decrement
         exec_pkg::OP_POP: begin
            sp = sp + 16'h0001; // Pre-increment
            ea = sp;
         end
         exec_pkg::OP_PMR: begin
            pt = pt + 16'(m == exec_pkg::MODE_POST_INC); // Step
            cyc = 3;
         end
         default: ;
      endcase
      if (op == exec_pkg::OP_PUSH) ea = sp + 16'h0001;
      {rf[27 + 2 * p], rf[26 + 2 * p]} = pt;
      if (op inside {exec_pkg::OP_ST, exec_pkg::OP_STO, exec_pkg::OP_STA,
            exec_pkg::OP_PUSH}) mem[ea[7:0]] = rf[rr];
      if (op inside {exec_pkg::OP_LD, exec_pkg::OP_LDO, exec_pkg::OP_LDA,
            exec_pkg::OP_POP}) rf[rd] = mem[ea[7:0]];
      if (op == exec_pkg::OP_PMR) rf[rd] = ea[7:0] ^ 8'ha5;
      @(posedge ref_clk_in);
      {op_in, rd_in, rr_in, bit_in, mode_in} <= {op, rd, rr, b, m};
      {ptr_sel_in, disp_in, addr_in, valid_in} <= {p, q, a, 1'b1};
      @(posedge ref_clk_in);
      valid_in <= 1'b0;
      #1;
      check(16'({sleep_out, wdt_restart_out, break_out}),
         16'({op == exec_pkg::OP_SLEEP, op == exec_pkg::OP_WDT,
         op == exec_pkg::OP_BREAK}));
      n = 1;
      while (ready_out !== 1'b1 && n < 9) begin
         @(posedge ref_clk_in);
         #1;
         n++;
      end
      check(16'(n), 16'(cyc)); // Cycle count
      check(16'(flags_out), 16'(fl)); // Flags
      check(sp_out, sp); // Stack pointer
      if (n >= 9) give_verdict();
   endtask

   // Read one register back through the debug port
   task automatic peek(input logic [4:0] i);
      @(posedge ref_clk_in);
      dbg_idx_in <= i;
      @(posedge ref_clk_in);
      #1;
      check(16'(dbg_data_out), 16'(rf[i])); // Contents
   endtask

   initial begin
      {op_in, rd_in, rr_in, bit_in, mode_in, ptr_sel_in} = '0;
      {disp_in, addr_in, valid_in, dbg_idx_in, fl, sp} = '0;
      rst_in = 1'b1;
      foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
      foreach (rf[i]) rf[i] = 8'h00;
      void'($urandom(78));
      repeat (2) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      for (int i = 16; i < 32; i++) run(exec_pkg::OP_LDA, 5'(i), '0, '0, '0,
         '0, '0, 16'($urandom));
      for (int b = 0; b < 16; b++) run(b < 8 ? exec_pkg::OP_FSET :
         exec_pkg::OP_FCLR, '0, '0, 3'(b), '0, '0, '0, '0);
      // Codes one to nine are the register and flag operations
      repeat (40) begin
         r = pick();
         run(5'(1 + $urandom % 9), r, pick(), 3'($urandom), '0, '0, '0, '0);
         peek(r);
         peek(r ^ 5'h01);
      end
      for (int k = 0; k < 9; k++) begin
         run(exec_pkg::OP_LD, pick(), '0, '0, 2'(k % 3), 2'(k / 3), '0, '0);
         run(exec_pkg::OP_ST, '0, pick(), '0, 2'(k % 3), 2'(k / 3), '0, '0);
      end
      for (int k = 0; k < 4; k++) begin
         run(exec_pkg::OP_LDO, pick(), '0, '0, '0, 2'(1 + k % 2),
            k < 2 ? 6'h3f : 6'($urandom), '0);
         run(exec_pkg::OP_STO, '0, pick(), '0, '0, 2'(2 - k % 2),
            k < 2 ? 6'h3f : 6'($urandom), '0);
         run(exec_pkg::OP_STA, '0, pick(), '0, '0, '0, '0, 16'($urandom));
      end
      repeat (3) run(exec_pkg::OP_PUSH, '0, pick(), '0, '0, '0, '0, '0);
      repeat (3) run(exec_pkg::OP_POP, pick(), '0, '0, '0, '0, '0, '0);
      for (int k = 0; k < 3; k++) run(exec_pkg::OP_PMR, 5'(k * 8), '0, '0,
         2'(k == 2), exec_pkg::PTR_Z, '0, '0);
      // The third code past sleep is unused and must act as nothing
      for (int k = 0; k < 4; k++) run(5'(exec_pkg::OP_SLEEP + k), '0, '0,
         '0, '0, '0, '0, '0);
      for (int i = 0; i < 32; i++) peek(5'(i));
      // A second reset clears flags, stack pointer and registers
      @(posedge ref_clk_in);
      rst_in <= 1'b1;
      @(posedge ref_clk_in);
      rst_in <= 1'b0;
      foreach (rf[i]) rf[i] = 8'h00;
      #1;
      check({8'h00, flags_out}, 16'h0000);
      check(sp_out, 16'h0000);
      peek(5'h1f);
      give_verdict();
   end
endmodule // cpu_instruction_execution_subset_bench
